// File: include/tbs_pkg.sv
/*
 * Constants and carrier types for the ten-bit serdes interface block.
 * Assumes a single reference clock for the core and two recovered link
 * clocks from the external serdes, 180 degrees apart.
 */
`default_nettype none
package tbs_pkg;
	localparam int   SYMBOL_W           = 10;
	localparam logic LOCK_TO_REF_LEVEL  = 1'b0;
	localparam logic LOOPBACK_RESET     = 1'b0;
	localparam logic COMMA_EN_RESET     = 1'b0;
	localparam logic [SYMBOL_W-1:0] SYMBOL_RESET = 10'h000;
	localparam logic [2:0]          SYNC_RESET   = 3'h0;

	typedef logic [SYMBOL_W-1:0] tbs_symbol_type;

	// Receive synchronisation engine states, as driven by the pcs
	typedef enum logic [1:0] {
		sync_lost_state,
		comma_wait_state,
		acquire_state,
		in_sync_state
	} tbs_sync_type;

	// One even/odd pair of received code groups, even first on the wire
	typedef struct packed {
		tbs_symbol_type even;
		tbs_symbol_type odd;
	} tbs_pair_type;

	// Reference clock domain state
	typedef struct packed {
		tbs_symbol_type tx_code;
		logic           loopback;
		logic           lock_to_ref;
		logic           comma_en;
		logic [2:0]     toggle_sync;
		logic           toggle_seen;
		tbs_pair_type   pair;
		logic           odd_pending;
		tbs_symbol_type rx_code;
		logic           rx_valid;
	} tbs_core_type;

	// Phase a recovered clock domain state
	typedef struct packed {
		tbs_symbol_type even;
		tbs_pair_type   pair;
		logic           primed;
		logic           toggle;
	} tbs_link_type;
endpackage : tbs_pkg
`default_nettype wire

// File: verilog/tbs_tbi.sv
/*
 * Ten-bit interface between the pcs and an external serdes: transmit code
 * groups and control levels on the reference clock, receive code groups
 * captured on two recovered clocks and merged into one ordered stream.
 * Assumes the recovered clocks come from one source, 180 degrees apart, and
 * that a pair period is longer than the toggle crossing (about 4 clk).
 */
`timescale 1ns/100ps
`default_nettype none
module tbs_tbi (
	// Core clock and reset
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Pcs transmit and control side
	input  wire tbs_pkg::tbs_symbol_type pcs_tx_code,
	input  wire logic                    pcs_loopback,
	input  wire tbs_pkg::tbs_sync_type   pcs_sync_state,
	// Pcs receive stream
	output var  tbs_pkg::tbs_symbol_type pcs_rx_code,
	output var  logic                    pcs_rx_valid,
	// Serdes transmit pins
	output var  tbs_pkg::tbs_symbol_type serdes_tx_code,
	output var  logic                    serdes_loopback,
	output var  logic                    serdes_lock_to_ref,
	output var  logic                    serdes_comma_align_en,
	// Serdes receive pins
	input  wire logic                    recovered_clock_phase_a,
	input  wire logic                    recovered_clock_phase_b,
	input  wire tbs_pkg::tbs_symbol_type rx_symbol_even,
	input  wire tbs_pkg::tbs_symbol_type rx_symbol_odd
);

	tbs_pkg::tbs_core_type   core;
	tbs_pkg::tbs_core_type   next_core;
	tbs_pkg::tbs_link_type   link;
	tbs_pkg::tbs_link_type   next_link;
	tbs_pkg::tbs_symbol_type odd_hold;
	logic                    pair_event;

	// Phase b domain: the odd code lands half a period after its even mate
	always_ff @(posedge recovered_clock_phase_b or negedge nrst) begin
		if (!nrst) begin
			odd_hold <= tbs_pkg::SYMBOL_RESET;
		end else begin
			odd_hold <= rx_symbol_odd;
		end
	end

	// Phase a domain. Reading odd_hold here is a fixed half-period path
	// between related clocks, not an asynchronous crossing.
	always_comb begin
		next_link = link;
		next_link.even = rx_symbol_even;
		if (link.primed) begin
			next_link.pair.even = link.even;
			next_link.pair.odd  = odd_hold;
			next_link.toggle    = ~link.toggle;
		end
		next_link.primed = 1'b1;
	end

	always_ff @(posedge recovered_clock_phase_a or negedge nrst) begin
		if (!nrst) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	// Phase a checks. The first edge after reset only primes, so a pair
	// never mixes a stale even code with a fresh odd one.
	prime_first_a: assert property (@(posedge recovered_clock_phase_a) disable iff (!nrst)
		!link.primed |=> link.toggle == $past(link.toggle))
		else $error("pair handed over before priming");

	toggle_flip_a: assert property (@(posedge recovered_clock_phase_a) disable iff (!nrst)
		link.primed |=> link.toggle != $past(link.toggle))
		else $error("toggle did not flip for a pair");

	pair_order_a: assert property (@(posedge recovered_clock_phase_a) disable iff (!nrst)
		link.primed |=> link.pair.even == $past(link.even) && link.pair.odd == $past(odd_hold))
		else $error("pair not formed from previous even and its odd");

	// Toggle is counted once the second and third sync stages agree;
	// the pair word is stable for a whole phase a period around it.
	assign pair_event = (core.toggle_sync[1] == core.toggle_sync[2])
		&& (core.toggle_sync[2] != core.toggle_seen);

	always_comb begin
		next_core = core;
		next_core.tx_code     = pcs_tx_code;
		next_core.loopback    = pcs_loopback;
		next_core.lock_to_ref = tbs_pkg::LOCK_TO_REF_LEVEL;
		next_core.comma_en    = (pcs_sync_state == tbs_pkg::sync_lost_state);
		next_core.toggle_sync = {core.toggle_sync[1:0], link.toggle};
		next_core.rx_valid    = 1'b0;
		if (pair_event) begin
			next_core.toggle_seen = core.toggle_sync[2];
			next_core.pair        = link.pair;
			next_core.rx_code     = link.pair.even;
			next_core.rx_valid    = 1'b1;
			next_core.odd_pending = 1'b1;
		end else if (core.odd_pending) begin
			next_core.rx_code     = core.pair.odd;
			next_core.rx_valid    = 1'b1;
			next_core.odd_pending = 1'b0;
		end
	end

	// Single reference clock for every core register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core             <= '0;
			core.tx_code     <= tbs_pkg::SYMBOL_RESET;
			core.loopback    <= tbs_pkg::LOOPBACK_RESET;
			core.lock_to_ref <= tbs_pkg::LOCK_TO_REF_LEVEL;
			core.comma_en    <= tbs_pkg::COMMA_EN_RESET;
			core.toggle_sync <= tbs_pkg::SYNC_RESET;
		end else begin
			core <= next_core;
		end
	end

	assign serdes_tx_code        = core.tx_code;
	assign serdes_loopback       = core.loopback;
	assign serdes_lock_to_ref    = core.lock_to_ref;
	assign serdes_comma_align_en = core.comma_en;
	assign pcs_rx_code           = core.rx_code;
	assign pcs_rx_valid          = core.rx_valid;

	lock_low_a: assert property (@(posedge clk) disable iff (!nrst)
		!serdes_lock_to_ref)
		else $error("lock to reference not low");

	tx_follow_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 serdes_tx_code == $past(pcs_tx_code))
		else $error("transmit code not presented next cycle");

	loop_follow_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 serdes_loopback == $past(pcs_loopback))
		else $error("loopback request not forwarded");

	comma_en_a: assert property (@(posedge clk) disable iff (!nrst)
		##1 serdes_comma_align_en == ($past(pcs_sync_state) == tbs_pkg::sync_lost_state))
		else $error("comma enable does not match sync lost state");

	even_cap_a: assert property (@(posedge recovered_clock_phase_a) disable iff (!nrst)
		##1 link.even == $past(rx_symbol_even))
		else $error("even code not captured on phase a");

	odd_cap_a: assert property (@(posedge recovered_clock_phase_b) disable iff (!nrst)
		##1 odd_hold == $past(rx_symbol_odd))
		else $error("odd code not captured on phase b");

	odd_next_a: assert property (@(posedge clk) disable iff (!nrst)
		pair_event |=> pcs_rx_valid ##1 (pcs_rx_valid && pcs_rx_code == $past(link.pair.odd, 2)))
		else $error("odd code does not follow even code");

	even_out_a: assert property (@(posedge clk) disable iff (!nrst)
		pair_event |=> pcs_rx_code == $past(link.pair.even))
		else $error("even code of pair not delivered first");

	valid_pairs_a: assert property (@(posedge clk) disable iff (!nrst)
		pcs_rx_valid ##1 pcs_rx_valid |=> !pcs_rx_valid)
		else $error("more than two codes per pair");

	// The pair word must stand still while the core takes it; if the pair
	// period ever shrinks below the toggle crossing, this is where it shows.
	pair_stable_a: assert property (@(posedge clk) disable iff (!nrst)
		pair_event |-> $stable(link.pair))
		else $error("pair word moved while being taken");

	event_single_a: assert property (@(posedge clk) disable iff (!nrst)
		pair_event |=> !pair_event)
		else $error("one toggle counted twice");

	even_then_odd_a: assert property (@(posedge clk) disable iff (!nrst)
		pcs_rx_valid && !$past(pcs_rx_valid) |=> pcs_rx_valid)
		else $error("even code not followed by its odd code");

	rx_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		!link.primed |-> !pcs_rx_valid)
		else $error("receive code delivered before any pair");

	valid_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		!pair_event && !core.odd_pending |=> !pcs_rx_valid)
		else $error("receive valid without a pair");

	pend_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		core.odd_pending |=> !core.odd_pending)
		else $error("odd code delivered more than once");

	comma_off_a: assert property (@(posedge clk) disable iff (!nrst)
		pcs_sync_state != tbs_pkg::sync_lost_state |=> !serdes_comma_align_en)
		else $error("comma enable high outside sync lost state");

	// Outputs still show their reset values at the first edge after release
	reset_out_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> serdes_tx_code == tbs_pkg::SYMBOL_RESET
			&& serdes_loopback == tbs_pkg::LOOPBACK_RESET && !pcs_rx_valid)
		else $error("outputs not at reset values after reset");

	pair_cov: cover property (@(posedge clk) disable iff (!nrst)
		pair_event ##1 pcs_rx_valid ##1 pcs_rx_valid);
	loop_cov: cover property (@(posedge clk) disable iff (!nrst)
		$rose(serdes_loopback));
	comma_cov: cover property (@(posedge clk) disable iff (!nrst)
		$fell(serdes_comma_align_en));
	comma_rise_cov: cover property (@(posedge clk) disable iff (!nrst)
		$rose(serdes_comma_align_en));
	loop_rx_cov: cover property (@(posedge clk) disable iff (!nrst)
		serdes_loopback && pcs_rx_valid);

endmodule : tbs_tbi
`default_nettype wire

// File: tb/tbs_serdes_model.sv
/*
 * Serdes model: free recovered clocks while run is high, code pairs.
 * Assumes the core captures even on phase a rises and odd on phase b.
 */
`timescale 1ns/100ps
`default_nettype none
module tbs_serdes_model (
	// Control from bench and serdes pins
	input  wire logic                    run,
	input  wire logic                    loopback,
	input  wire tbs_pkg::tbs_symbol_type tx_code,
	// Receive pins
	output var  logic                    clk_a,
	output var  logic                    clk_b,
	output var  tbs_pkg::tbs_symbol_type even,
	output var  tbs_pkg::tbs_symbol_type odd
);
	tbs_pkg::tbs_symbol_type cnt;
	initial begin
		cnt = 10'h000;
		clk_a = 1'b0;
		clk_b = 1'b0;
		even = 10'h155;
		odd = 10'h2aa;
		forever begin
			#24;
			clk_a = run;
			clk_b = 1'b0;
			// Odd moves on the phase b fall, far from its capture edge
			odd = loopback ? tx_code : (run ? cnt + 10'h001 : ~odd);
			if (run) cnt = cnt + 10'h002;
			#24;
			clk_a = 1'b0;
			clk_b = run;
			// Idle even shows the next code, so the first capture is code 0
			even = loopback ? tx_code : cnt;
		end
	end
endmodule : tbs_serdes_model
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Bench for the ten-bit interface: transmit controls and receive stream.
 * Assumes the serdes model in tbs_serdes_model.sv.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic                    clk, nrst, lpbk, run, ca, cb, rxv, slb, lref, cen;
	tbs_pkg::tbs_symbol_type txc, rxc, stx, ev, od;
	tbs_pkg::tbs_sync_type   sst;
	int                      n_mismatch = 0;
	int                      num_checks = 0;
	tbs_tbi dut (.clk(clk), .nrst(nrst), .pcs_tx_code(txc), .pcs_loopback(lpbk),
		.pcs_sync_state(sst), .pcs_rx_code(rxc), .pcs_rx_valid(rxv),
		.serdes_tx_code(stx), .serdes_loopback(slb), .serdes_lock_to_ref(lref),
		.serdes_comma_align_en(cen), .recovered_clock_phase_a(ca),
		.recovered_clock_phase_b(cb), .rx_symbol_even(ev), .rx_symbol_odd(od));
	tbs_serdes_model model (.run(run), .loopback(slb), .tx_code(stx),
		.clk_a(ca), .clk_b(cb), .even(ev), .odd(od));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// Inputs change every cycle; each set but the last is checked one cycle later
	task automatic tx_ctrl_test;
		for (int i = 0; i < 9; i++) begin
			@(negedge clk);
			if (i > 0) begin
				chk("tx code", txc, stx);
				chk("loopback", {9'h000, lpbk}, {9'h000, slb});
				chk("lock ref", 10'h000, {9'h000, lref});
				chk("comma en", {9'h000, sst == tbs_pkg::sync_lost_state}, {9'h000, cen});
			end
			txc = 10'h3a5 ^ 10'(i * 73);
			lpbk = i[0];
			sst = tbs_pkg::tbs_sync_type'(i[1:0]);
		end
	endtask : tx_ctrl_test
	// Skip drops codes left over from before a loopback change
	task automatic rx_stream_test(input logic lb, input logic [9:0] k, input int skip);
		int         n;
		int         t;
		n = 0;
		t = 0;
		@(negedge clk);
		lpbk = lb;
		txc = k;
		run = 1'b1;
		while (n < 8 && t < 2000) begin
			@(negedge clk);
			t++;
			if (rxv === 1'b1 && skip > 0) skip--;
			else if (rxv === 1'b1) begin
				if (lb) chk("loop rx", k, rxc);
				else chk("rx order", 10'(n), rxc);
				n++;
			end
		end
		if (t >= 2000) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : rx_stream_test
	initial begin
		nrst = 1'b0;
		txc = 10'h000;
		lpbk = 1'b0;
		run = 1'b0;
		sst = tbs_pkg::in_sync_state;
		repeat (16) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		tx_ctrl_test();
		rx_stream_test(1'b0, 10'h000, 0);
		rx_stream_test(1'b1, 10'h17c, 4);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
